// >>> isr_map.vh
// Constants for the status and event reporting block: positions, widths, codes, depths
`ifndef ISR_MAP_VH
`define ISR_MAP_VH

// ==========================================================
// Status byte positions
`define ISR_STB_UNUSED0      0
`define ISR_STB_UNUSED1      1
`define ISR_STB_ERRQ         2
`define ISR_STB_QUESTIONABLE_SUMMARY         3
`define ISR_STB_MAV          4
`define ISR_STB_ESB          5
`define ISR_STB_RQS          6
`define ISR_STB_OPERATION_SUMMARY         7

// ==========================================================
// Standard event status positions
`define ISR_ESR_OPC          0
`define ISR_ESR_UNUSED1      1
`define ISR_ESR_QYE          2
`define ISR_ESR_DDE          3
`define ISR_ESR_EXE          4
`define ISR_ESR_CME          5
`define ISR_ESR_LOCAL        6
`define ISR_ESR_PON          7

// ==========================================================
// Widths and reset values
`define ISR_BYTE_W           8
`define ISR_QUESTIONABLE_SUMMARY_W           15
`define ISR_CODE_W           16
`define ISR_ESR_RST          8'h00
`define ISR_ESE_RST          8'h00
`define ISR_SRE_RST          8'h00
`define ISR_QEN_RST          15'h0000
`define ISR_QEV_RST          15'h0000
`define ISR_ESR_WR_MASK      8'hFD
`define ISR_SRE_WR_MASK      8'hBC

// ==========================================================
// Error codes and class bounds (two's complement, 16 bits)
`define ISR_CODE_NONE        16'h0000
`define ISR_CODE_OVERFLOW    16'hFEA2
`define ISR_CLASS_100_HI     (-100)
`define ISR_CLASS_200_HI     (-200)
`define ISR_CLASS_300_HI     (-300)
`define ISR_CLASS_400_HI     (-400)
`define ISR_CLASS_400_LO     (-499)

// ==========================================================
// Queue depths as address widths
`define ISR_OUTQ_AW          4
`define ISR_ERRQ_AW          3

`endif

// >>> isr_fifo.v
// Small first-in first-out queue with flush, used for responses and for errors
`default_nettype none

module isr_fifo #(
  parameter W  = 8,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          en,
  input  wire          flush,
  input  wire          push,
  input  wire [W-1:0]  din,
  input  wire          pop,
  output wire [W-1:0]  dout,
  output wire [AW:0]   count,
  output wire          empty,
  output wire          full
);

  localparam [AW:0] FULL_CNT = 1 << AW;
  localparam [AW:0] ONE_CNT  = 1;

  reg [W-1:0]  mem [0:(1<<AW)-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0]   cnt_ff;

  // ==========================================================
  // Accepted moves; a flush empties first, so a push beside it survives
  wire          push_ok = push && (flush || (cnt_ff != FULL_CNT));
  wire          pop_ok  = pop && !flush && (cnt_ff != {(AW+1){1'b0}});
  wire [AW-1:0] wr_addr = flush ? {AW{1'b0}} : wr_ff;

  assign dout  = mem[rd_ff];
  assign count = cnt_ff;
  assign empty = (cnt_ff == {(AW+1){1'b0}});
  assign full  = (cnt_ff == FULL_CNT);

  // Storage carries no reset; only the pointers decide what is valid
  always @(posedge clk) begin
    if (en && push_ok) begin
      mem[wr_addr] <= din;
    end
  end

  // Pointers and occupancy
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (en) begin
      if (flush) begin
        rd_ff  <= {AW{1'b0}};
        wr_ff  <= push_ok ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
        cnt_ff <= push_ok ? ONE_CNT : {(AW+1){1'b0}};
      end else begin
        if (push_ok) begin
          wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop_ok) begin
          rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
        end
        case ({push_ok, pop_ok})
          2'b10:   cnt_ff <= cnt_ff + ONE_CNT;
          2'b01:   cnt_ff <= cnt_ff - ONE_CNT;
          default: cnt_ff <= cnt_ff;
        endcase
      end
    end
  end

endmodule // isr_fifo

`default_nettype wire

// >>> isr_status_top.v
// Status byte, standard event, questionable event, enable masks and both queues
`include "isr_map.vh"
`default_nettype none

// Notes on behaviour
// - Status byte bits 0 and 1 always read zero.
// - Status byte bit 2 is high while the error queue holds entries.
// - Status byte bit 3 is OR of questionable events ANDed with their enables.
// - Status byte bit 4 is high while the output queue holds a response.
// - Status byte bit 5 is OR of standard events ANDed with their enables.
// - Status byte bit 6 shows the device requests service.
// - Status byte bit 7 summarizes operation events, which never occur: zero.
// - Serial poll and status byte query return identical content.
// - Event bit 0 sets once operations pending at the completion command finish.
// - Standard event bit 1 always reads zero.
// - Event bits 2..5: query, device, execution, parse errors.
// - Event bit 6 on local key press, bit 7 on power up.
// - Reading standard events returns them, then clears every bit not set in that same cycle.
// - Every summary is OR over positions of status AND enable.
// - Standard event mask: one bit per position, written, read, gates bit 5.
// - Questionable mask selects events for bit 3, written and read back.
// - Service request mask selects status bits causing requests; written, read.
// - A new message after a terminator empties the output queue.
// - Error queue is first-in first-out; each error query pops the oldest.
// - On overflow record code -350 and refuse entries until read or cleared.
// - Logged error sets event bit: -100 bit 5, -200 4, -300 3, -400 2.
// - Questionable events latch rising conditions and hold until read or cleared.
module isr_status_top (
  input  wire        MCLK,
  input  wire        RSTN,
  input  wire        CE,
  input  wire        STB_QUERY,
  input  wire        SERIAL_POLL,
  input  wire        ESR_QUERY,
  input  wire        ESE_WRITE,
  input  wire        ESE_QUERY,
  input  wire        SRE_WRITE,
  input  wire        SRE_QUERY,
  input  wire        QEN_WRITE,
  input  wire        QEN_QUERY,
  input  wire        QEV_QUERY,
  input  wire        ERR_QUERY,
  input  wire        RESP_READ,
  input  wire [15:0] WR_DATA,
  input  wire        CLEAR_STATUS,
  input  wire        OPC_CMD,
  input  wire        OPS_PENDING,
  input  wire        LOCAL_KEY,
  input  wire [14:0] QUESTIONABLE_SUMMARY_COND,
  input  wire        ERR_LOG,
  input  wire [15:0] ERR_CODE,
  input  wire        RESP_PUSH,
  input  wire [7:0]  RESP_DATA,
  input  wire        MSG_START,
  output reg  [15:0] RD_DATA,
  output reg         RD_VALID,
  output wire [7:0]  STATUS_BYTE,
  output wire        SRQ,
  output wire        RESP_FULL
);

  // ==========================================================
  // State registers
  reg [`ISR_BYTE_W-1:0] standard_event_status_ff;
  reg [`ISR_BYTE_W-1:0] standard_event_enable_ff;
  reg [`ISR_BYTE_W-1:0] service_request_enable_ff;
  reg [`ISR_QUESTIONABLE_SUMMARY_W-1:0] questionable_event_reg_ff;
  reg [`ISR_QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_enable_ff;
  reg [`ISR_QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_cond_prev_ff;
  reg                   opc_armed_ff;
  reg                   pon_done_ff;
  reg                   errq_locked_ff;
  reg [15:0]            rd_data_ff;
  reg                   rd_valid_ff;

  reg [`ISR_BYTE_W-1:0] nxt_standard_event_status;
  reg [`ISR_QUESTIONABLE_SUMMARY_W-1:0] nxt_questionable_event_reg;
  reg [`ISR_BYTE_W-1:0] esr_set;
  reg [15:0]            nxt_rd_data;
  reg                   nxt_rd_valid;
  reg                   errq_push;
  reg [15:0]            errq_din;
  reg                   nxt_errq_locked;

  wire [7:0]                outq_dout;
  wire [`ISR_OUTQ_AW:0]     outq_count;
  wire                      outq_empty;
  wire [15:0]               errq_dout;
  wire [`ISR_ERRQ_AW:0]     errq_count;
  wire                      errq_empty;
  wire                      errq_full;

  // ==========================================================
  // Output queue: flushed by each new message so stale answers vanish
  isr_fifo #(
    .W  (`ISR_BYTE_W),
    .AW (`ISR_OUTQ_AW)
  ) u_outq (
    .clk   (MCLK),
    .rst_n (RSTN),
    .en    (CE),
    .flush (MSG_START),
    .push  (RESP_PUSH),
    .din   (RESP_DATA),
    .pop   (RESP_READ),
    .dout  (outq_dout),
    .count (outq_count),
    .empty (outq_empty),
    .full  (RESP_FULL)
  );

  // ==========================================================
  // Error queue, oldest entry at the head
  isr_fifo #(
    .W  (`ISR_CODE_W),
    .AW (`ISR_ERRQ_AW)
  ) u_errq (
    .clk   (MCLK),
    .rst_n (RSTN),
    .en    (CE),
    .flush (CLEAR_STATUS),
    .push  (errq_push),
    .din   (errq_din),
    .pop   (ERR_QUERY),
    .dout  (errq_dout),
    .count (errq_count),
    .empty (errq_empty),
    .full  (errq_full)
  );

  // ==========================================================
  // Summaries and the status byte, all from flip-flops
  wire questionable_summary_summary  = |(questionable_event_reg_ff & questionable_summary_enable_ff);
  wire event_summary = |(standard_event_status_ff & standard_event_enable_ff);
  wire operation_summary = 1'b0;

  // Bit 6 is left out of the request term so it cannot hold itself up
  wire [7:0] stb_base;
  assign stb_base[`ISR_STB_UNUSED0] = 1'b0;
  assign stb_base[`ISR_STB_UNUSED1] = 1'b0;
  assign stb_base[`ISR_STB_ERRQ]    = !errq_empty;
  assign stb_base[`ISR_STB_QUESTIONABLE_SUMMARY]    = questionable_summary_summary;
  assign stb_base[`ISR_STB_MAV]     = !outq_empty;
  assign stb_base[`ISR_STB_ESB]     = event_summary;
  assign stb_base[`ISR_STB_RQS]     = 1'b0;
  assign stb_base[`ISR_STB_OPERATION_SUMMARY]    = operation_summary;

  wire service_request_flag = |(stb_base & service_request_enable_ff & `ISR_SRE_WR_MASK);

  assign STATUS_BYTE = stb_base | ({7'h00, service_request_flag} << `ISR_STB_RQS);
  assign SRQ         = service_request_flag;
  wire   unused_cnt  = |{outq_count, errq_count};

  // ==========================================================
  // Error class of a logged code, signed compare on 16 bits
  wire signed [15:0] code_s = ERR_CODE;
  wire cls_100 = (code_s <= `ISR_CLASS_100_HI) && (code_s > `ISR_CLASS_200_HI);
  wire cls_200 = (code_s <= `ISR_CLASS_200_HI) && (code_s > `ISR_CLASS_300_HI);
  wire cls_300 = (code_s <= `ISR_CLASS_300_HI) && (code_s > `ISR_CLASS_400_HI);
  wire cls_400 = (code_s <= `ISR_CLASS_400_HI) && (code_s >= `ISR_CLASS_400_LO);

  // Error logging; last free slot is kept for the overflow marker
  always @* begin
    errq_push       = 1'b0;
    errq_din        = ERR_CODE;
    nxt_errq_locked = errq_locked_ff;
    if (CLEAR_STATUS || ERR_QUERY) begin
      nxt_errq_locked = 1'b0;
    end
    if (ERR_LOG && !errq_locked_ff && !errq_full) begin
      errq_push = 1'b1;
      if (errq_count == {1'b0, {`ISR_ERRQ_AW{1'b1}}} && !ERR_QUERY && !CLEAR_STATUS) begin
        errq_din        = `ISR_CODE_OVERFLOW;
        nxt_errq_locked = 1'b1;
      end
    end
  end

  // ==========================================================
  // Standard event set terms; a set arriving with a clear wins
  always @* begin
    esr_set = 8'h00;
    if (opc_armed_ff && !OPS_PENDING) begin
      esr_set[`ISR_ESR_OPC] = 1'b1;
    end
    if (ERR_LOG) begin
      esr_set[`ISR_ESR_CME] = cls_100;
      esr_set[`ISR_ESR_EXE] = cls_200;
      esr_set[`ISR_ESR_DDE] = cls_300 || (errq_push && (errq_din == `ISR_CODE_OVERFLOW));
      esr_set[`ISR_ESR_QYE] = cls_400;
    end
    if (LOCAL_KEY) begin
      esr_set[`ISR_ESR_LOCAL] = 1'b1;
    end
    if (!pon_done_ff) begin
      esr_set[`ISR_ESR_PON] = 1'b1;
    end
    nxt_standard_event_status = ((ESR_QUERY || CLEAR_STATUS) ? 8'h00 : standard_event_status_ff) | esr_set;
    nxt_standard_event_status[`ISR_ESR_UNUSED1] = 1'b0;
  end

  // Questionable events latch rising edges of the condition inputs
  always @* begin
    nxt_questionable_event_reg = ((QEV_QUERY || CLEAR_STATUS) ? `ISR_QEV_RST : questionable_event_reg_ff)
                                 | (QUESTIONABLE_SUMMARY_COND & ~questionable_summary_cond_prev_ff);
  end

  // ==========================================================
  // Query answers; one query per cycle, the first listed wins
  always @* begin
    nxt_rd_data  = rd_data_ff;
    nxt_rd_valid = 1'b0;
    if (STB_QUERY || SERIAL_POLL) begin
      nxt_rd_data  = {8'h00, STATUS_BYTE};
      nxt_rd_valid = 1'b1;
    end else if (ESR_QUERY) begin
      nxt_rd_data  = {8'h00, standard_event_status_ff};
      nxt_rd_valid = 1'b1;
    end else if (ESE_QUERY) begin
      nxt_rd_data  = {8'h00, standard_event_enable_ff};
      nxt_rd_valid = 1'b1;
    end else if (SRE_QUERY) begin
      nxt_rd_data  = {8'h00, service_request_enable_ff};
      nxt_rd_valid = 1'b1;
    end else if (QEN_QUERY) begin
      nxt_rd_data  = {1'b0, questionable_summary_enable_ff};
      nxt_rd_valid = 1'b1;
    end else if (QEV_QUERY) begin
      nxt_rd_data  = {1'b0, questionable_event_reg_ff};
      nxt_rd_valid = 1'b1;
    end else if (ERR_QUERY) begin
      nxt_rd_data  = errq_empty ? `ISR_CODE_NONE : errq_dout;
      nxt_rd_valid = 1'b1;
    end else if (RESP_READ) begin
      nxt_rd_data  = {8'h00, outq_dout};
      nxt_rd_valid = !outq_empty;
    end
  end

  // ==========================================================
  // Sequential state; CE low freezes everything
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      standard_event_status_ff  <= `ISR_ESR_RST;
      standard_event_enable_ff  <= `ISR_ESE_RST;
      service_request_enable_ff <= `ISR_SRE_RST;
      questionable_event_reg_ff <= `ISR_QEV_RST;
      questionable_summary_enable_ff            <= `ISR_QEN_RST;
      questionable_summary_cond_prev_ff         <= `ISR_QEV_RST;
      opc_armed_ff              <= 1'b0;
      pon_done_ff               <= 1'b0;
      errq_locked_ff            <= 1'b0;
      rd_data_ff                <= 16'h0000;
      rd_valid_ff               <= 1'b0;
    end else if (CE) begin
      standard_event_status_ff  <= nxt_standard_event_status;
      questionable_event_reg_ff <= nxt_questionable_event_reg;
      questionable_summary_cond_prev_ff         <= QUESTIONABLE_SUMMARY_COND;
      pon_done_ff               <= 1'b1;
      errq_locked_ff            <= nxt_errq_locked;
      rd_data_ff                <= nxt_rd_data;
      rd_valid_ff               <= nxt_rd_valid;
      if (ESE_WRITE) begin
        standard_event_enable_ff <= WR_DATA[7:0];
      end
      if (SRE_WRITE) begin
        service_request_enable_ff <= WR_DATA[7:0];
      end
      if (QEN_WRITE) begin
        questionable_summary_enable_ff <= WR_DATA[14:0];
      end
      // A fresh completion command re-arms; completion disarms
      if (OPC_CMD) begin
        opc_armed_ff <= 1'b1;
      end else if (opc_armed_ff && !OPS_PENDING) begin
        opc_armed_ff <= 1'b0;
      end
    end
  end

  always @* begin
    RD_DATA  = rd_data_ff;
    RD_VALID = rd_valid_ff & ~(unused_cnt & 1'b0);
  end

endmodule // isr_status_top

`default_nettype wire

// >>> isr_ctrl_model.sv
// Bus controller model that issues serial polls, response reads and new messages
`default_nettype none

module isr_ctrl_model (
  input  wire logic MCLK,
  output wire logic SERIAL_POLL,
  output wire logic RESP_READ,
  output wire logic MSG_START
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========
  // Strobes, bit 0 poll, bit 1 response read, bit 2 new message
  logic [2:0] req = 3'b000;
  assign {MSG_START, RESP_READ, SERIAL_POLL} = req;

  // One strobe per call; slow delays it, as a busy controller would
  task automatic strobe(input int k, input int slow);
    repeat (slow) @(posedge MCLK);
    @(posedge MCLK);
    #1 req[k] = 1'b1;
    @(posedge MCLK);
    #1 req[k] = 1'b0;
  endtask
endmodule // isr_ctrl_model

`default_nettype wire

// >>> isr_status_top_chk.sv
// Port-level assertions for the status reporting block
`default_nettype none

module isr_status_top_chk (
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic        STB_QUERY,
  input wire logic        SERIAL_POLL,
  input wire logic        ESR_QUERY,
  input wire logic        ESE_WRITE,
  input wire logic        ESE_QUERY,
  input wire logic        SRE_WRITE,
  input wire logic        ERR_QUERY,
  input wire logic        CLEAR_STATUS,
  input wire logic        ERR_LOG,
  input wire logic        RESP_PUSH,
  input wire logic        RESP_READ,
  input wire logic        MSG_START,
  input wire logic [15:0] WR_DATA,
  input wire logic [15:0] RD_DATA,
  input wire logic        RD_VALID,
  input wire logic [7:0]  STATUS_BYTE,
  input wire logic        SRQ,
  input wire logic        RESP_FULL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // ==========
  // Mask mirrors, so answers and requests tie back to the writes
  logic [7:0] ese_ff;
  logic [7:0] sre_ff;
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ese_ff <= 8'h00;
      sre_ff <= 8'h00;
    end else if (CE) begin
      if (ESE_WRITE) ese_ff <= WR_DATA[7:0];
      if (SRE_WRITE) sre_ff <= WR_DATA[7:0];
    end
  end

  // ==========
  // Request steps
  sequence s_stb_take;
    CE && (STB_QUERY || SERIAL_POLL);
  endsequence
  sequence s_ese_take;
    CE && ESE_QUERY && !STB_QUERY && !SERIAL_POLL && !ESR_QUERY;
  endsequence

  chk_fixed_zero: assert property (STATUS_BYTE[1:0] == 2'b00 && !STATUS_BYTE[7])
    else $error("status byte unused bits not zero");
  chk_rqs_mirror: assert property (STATUS_BYTE[6] == SRQ)
    else $error("request bit differs from service request line");
  chk_srq_cause: assert property (SRQ == |(STATUS_BYTE & sre_ff & 8'hBF))
    else $error("service request not the enabled summary");
  chk_stb_answer: assert property (s_stb_take |=> RD_VALID && RD_DATA == {8'h00, $past(STATUS_BYTE)})
    else $error("status byte answer wrong");
  chk_ese_answer: assert property (s_ese_take |=> RD_VALID && RD_DATA == {8'h00, $past(ese_ff)})
    else $error("event mask readback wrong");
  chk_err_flag: assert property (CE && ERR_LOG && !ERR_QUERY && !CLEAR_STATUS |=> STATUS_BYTE[2])
    else $error("error entry not flagged");
  chk_resp_flag: assert property (CE && RESP_PUSH && !RESP_READ && !RESP_FULL |=> STATUS_BYTE[4])
    else $error("response not flagged");
  chk_flush_empty: assert property (CE && MSG_START && !RESP_PUSH |=> !STATUS_BYTE[4])
    else $error("output queue not flushed");
endmodule // isr_status_top_chk

bind isr_status_top isr_status_top_chk chk_i (
  .MCLK(MCLK), .RSTN(RSTN), .CE(CE), .STB_QUERY(STB_QUERY), .SERIAL_POLL(SERIAL_POLL),
  .ESR_QUERY(ESR_QUERY), .ESE_WRITE(ESE_WRITE), .ESE_QUERY(ESE_QUERY), .SRE_WRITE(SRE_WRITE),
  .ERR_QUERY(ERR_QUERY), .CLEAR_STATUS(CLEAR_STATUS), .ERR_LOG(ERR_LOG), .RESP_PUSH(RESP_PUSH),
  .RESP_READ(RESP_READ), .MSG_START(MSG_START), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .STATUS_BYTE(STATUS_BYTE), .SRQ(SRQ), .RESP_FULL(RESP_FULL)
);

`default_nettype wire

// >>> isr_status_top_tb.sv
// Self-checking testbench for the status and event reporting block
`default_nettype none

module isr_status_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int STB = 0, ESR = 1, ESEW = 2, ESEQ = 3, SREW = 4, SREQ = 5, QENW = 6, QENQ = 7;
  localparam int QEV = 8, ERRQ = 9, CLR = 10, OPERATIONS_DONE_FLAG = 11, LOC = 12, LOG = 13, PUSH = 14;
  logic        MCLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        CE = 1'b1;
  logic        OPS_PENDING = 1'b0;
  logic [14:0] stb = 15'h0000;
  logic [14:0] QUESTIONABLE_SUMMARY_COND = 15'h0000;
  logic [15:0] dat = 16'h0000;
  logic [15:0] RD_DATA;
  logic        RD_VALID, SRQ, RESP_FULL, SERIAL_POLL, RESP_READ, MSG_START;
  logic [7:0]  STATUS_BYTE;
  logic [31:0] lfsr = 32'h2236;
  logic [15:0] codes [9];
  logic [15:0] tbl [8] = '{16'hFF9C, 16'hFF6A, 16'hFF10, 16'hFED4, 16'hFEA2, 16'hFE52, 16'hFE0D, 16'hFFCE};
  int          fails = 0;
  int          samples_checked = 0;

  // Free-running 50 MHz clock
  always #10 MCLK = ~MCLK;

  isr_status_top dut (
    .MCLK(MCLK), .RSTN(RSTN), .CE(CE), .STB_QUERY(stb[STB]), .SERIAL_POLL(SERIAL_POLL),
    .ESR_QUERY(stb[ESR]), .ESE_WRITE(stb[ESEW]), .ESE_QUERY(stb[ESEQ]), .SRE_WRITE(stb[SREW]),
    .SRE_QUERY(stb[SREQ]), .QEN_WRITE(stb[QENW]), .QEN_QUERY(stb[QENQ]), .QEV_QUERY(stb[QEV]),
    .ERR_QUERY(stb[ERRQ]), .RESP_READ(RESP_READ), .WR_DATA(dat), .CLEAR_STATUS(stb[CLR]),
    .OPC_CMD(stb[OPERATIONS_DONE_FLAG]), .OPS_PENDING(OPS_PENDING), .LOCAL_KEY(stb[LOC]), .QUESTIONABLE_SUMMARY_COND(QUESTIONABLE_SUMMARY_COND),
    .ERR_LOG(stb[LOG]), .ERR_CODE(dat), .RESP_PUSH(stb[PUSH]), .RESP_DATA(dat[7:0]),
    .MSG_START(MSG_START), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .STATUS_BYTE(STATUS_BYTE),
    .SRQ(SRQ), .RESP_FULL(RESP_FULL)
  );

  isr_ctrl_model ctl (.MCLK(MCLK), .SERIAL_POLL(SERIAL_POLL), .RESP_READ(RESP_READ), .MSG_START(MSG_START));

  // ==========
  // Helpers
  function automatic logic [31:0] nxt_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Event bit expected from an error code; codes outside the classes set none
  function automatic logic [15:0] cls(input logic [15:0] c);
    int v;
    v = $signed(c);
    return (v <= -100 && v > -200) ? 16'h0020 : (v <= -200 && v > -300) ? 16'h0010 :
           (v <= -300 && v > -400) ? 16'h0008 : (v <= -400 && v > -500) ? 16'h0004 : 16'h0000;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_sb(input logic [7:0] exp);
    check("STATUS_BYTE", {8'h00, STATUS_BYTE}, {8'h00, exp});
  endtask

  // Strobe with data, raised after an edge and dropped after the taking edge
  task automatic pulse(input int i, input logic [15:0] v = 16'h0000);
    @(posedge MCLK);
    #1 stb[i] = 1'b1;
    dat = v;
    @(posedge MCLK);
    #1 stb[i] = 1'b0;
  endtask

  // Answer must stand in the cycle right after the taking edge
  task automatic query(input int i, input logic [15:0] exp);
    pulse(i);
    check("RD_DATA", (RD_VALID === 1'b1) ? RD_DATA : 16'hDEAD, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic end_sim;
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    fails++;
    end_sim();
  end

  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge MCLK);
    chk_sb(8'h00);
    #1 RSTN = 1'b1;
    query(ESR, 16'h0080);
    query(ESR, 16'h0000);
    pulse(LOC);
    query(ESR, 16'h0040);
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt_lfsr(lfsr);
      pulse(ESEW, lfsr[15:0]);
      query(ESEQ, {8'h00, lfsr[7:0]});
      pulse(SREW, lfsr[31:16]);
      query(SREQ, {8'h00, lfsr[23:16]});
      pulse(QENW, lfsr[15:0]);
      query(QENQ, {1'b0, lfsr[14:0]});
    end
    pulse(ESEW);
    pulse(SREW);
    pulse(QENW);
    // Every error class on its own, then the popped code
    foreach (tbl[k]) begin
      pulse(CLR);
      pulse(LOG, tbl[k]);
      chk_sb(8'h04);
      query(ESR, cls(tbl[k]));
      query(ERRQ, tbl[k]);
      chk_sb(8'h00);
    end
    // Nine logs into eight places: overflow entry, then refusal
    for (int k = 0; k < 9; k++) begin
      lfsr = nxt_lfsr(lfsr);
      codes[k] = 16'hFF38 - {10'h000, lfsr[5:0]};
      pulse(LOG, codes[k]);
    end
    query(ESR, 16'h0018);
    for (int k = 0; k < 7; k++) query(ERRQ, codes[k]);
    query(ERRQ, 16'hFEA2);
    query(ERRQ, 16'h0000);
    // Summary and service request, by query and by slow poll
    pulse(ESEW, 16'h0020);
    pulse(LOG, 16'hFF9C);
    chk_sb(8'h24);
    pulse(SREW, 16'h0020);
    chk_sb(8'h64);
    query(STB, 16'h0064);
    ctl.strobe(0, 3);
    check("POLL_VALID", {15'h0000, RD_VALID}, 16'h0001);
    check("POLL", RD_DATA, 16'h0064);
    pulse(ESEW);
    chk_sb(8'h04);
    query(ESR, 16'h0020);
    query(ERRQ, 16'hFF9C);
    // Questionable event latches a rise and holds after the fall
    pulse(QENW, 16'h0002);
    QUESTIONABLE_SUMMARY_COND = 15'h0003;
    idle(2);
    QUESTIONABLE_SUMMARY_COND = 15'h0000;
    idle(2);
    chk_sb(8'h08);
    query(QEV, 16'h0003);
    chk_sb(8'h00);
    // Completion waits for pending operations
    OPS_PENDING = 1'b1;
    pulse(OPERATIONS_DONE_FLAG);
    idle(3);
    query(ESR, 16'h0000);
    OPS_PENDING = 1'b0;
    idle(2);
    query(ESR, 16'h0001);
    // Output queue filled, head entry read back, then flushed by a new message
    for (int k = 0; k < 16; k++) pulse(PUSH, 16'h00A0 + k[15:0]);
    check("RESP_FULL", {15'h0000, RESP_FULL}, 16'h0001);
    chk_sb(8'h10);
    ctl.strobe(1, 0);
    check("RESP", RD_DATA, 16'h00A0);
    ctl.strobe(2, 0);
    chk_sb(8'h00);
    // Clock enable low: a key press in that cycle must leave no trace
    CE = 1'b0;
    pulse(LOC);
    CE = 1'b1;
    query(ESR, 16'h0000);
    // Second reset in mid-run brings power-on back
    RSTN = 1'b0;
    idle(2);
    chk_sb(8'h00);
    RSTN = 1'b1;
    query(ESR, 16'h0080);
    end_sim();
  end
endmodule // isr_status_top_tb

`default_nettype wire
